// [rtl/cvr_receiver.sv]
// Device end: receives vector packets and corrects buffer bytes in place.
`timescale 1ns/1ns
// Functional notes
// - Vector line sampled one bit per clock.
// - A packet is exactly 42 bits.
// - Packet opens with sync nibble 1101.
// - Then 22 address bits, MSB first.
// - Then 8 error pattern bits, MSB first.
// - Last 8 bits are check bits.
// - Reception runs independently of other work.
// - Sync detection drops the ready line.
// - Sender waits while ready is low.
// - Ready returns after the check completes.
// - Valid packet schedules a buffer read-modify-write.
// - Read byte, XOR pattern, write back.
// - Check failure raises the fault flag.
// - Enabled buffer parity error raises fault.
// - Check code is CRC x^8+x^7+x^2+1.
module cvr_receiver
  import cvr_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)(
  input  wire logic         clk,
  input  wire logic         rst,
  cvr_link_if.device        link,
  input  wire logic         parity_check_enable,
  output wire logic         mem_req,
  output wire logic         mem_we,
  output cvr_addr_type      mem_addr,
  output cvr_pat_type       mem_wdata,
  output logic              mem_wparity,
  input  wire cvr_pat_type  mem_rdata,
  input  wire logic         mem_rparity,
  input  wire logic         mem_ack,
  output logic              correction_done,
  output logic              packet_dropped
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(BUF_DEPTH);
  localparam logic [PTR_W:0]   CNT_ONE  = (PTR_W + 1)'(1);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
  localparam cvr_crc_type      CRC_SYNC = cvr_crc_after_sync();

  generate
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
      $error("BUF_DEPTH must be a power of two of at least two");
    end
  endgenerate

  // Packet reception.

  cvr_rx_state_type         rx_state;
  logic [SYNC_W-2:0]        window;
  logic [5:0]               bit_idx;
  cvr_crc_type              crc;
  logic [ADDR_W+PAT_W-1:0]  payload;

  wire logic        hunting   = (rx_state == CVR_HUNT);
  wire logic        receiving = (rx_state == CVR_RECV);
  wire logic        line_bit  = link.vector_data;
  wire logic        sync_hit  = hunting &
                                ({window, line_bit} == SYNC_PATTERN);
  wire logic        in_fields = (bit_idx < POS_CHECK);
  wire logic        last_bit  = receiving & (bit_idx == POS_LAST);
  wire cvr_crc_type next_crc  = cvr_crc_step(crc, line_bit);
  wire logic        pkt_good  = last_bit & (next_crc == CRC_INIT);
  wire logic        pkt_bad   = last_bit & (next_crc != CRC_INIT);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state <= CVR_HUNT;
      window   <= '0;
      bit_idx  <= POS_ZERO;
      crc      <= CRC_INIT;
    end else if (sync_hit) begin
      rx_state <= CVR_RECV;
      window   <= '0;
      bit_idx  <= POS_ADDR;
      crc      <= CRC_SYNC;
    end else if (hunting) begin
      window   <= {window[SYNC_W-3:0], line_bit};
    end else begin
      bit_idx  <= bit_idx + POS_STEP;
      crc      <= next_crc;
      if (last_bit) begin
        rx_state <= CVR_HUNT;
      end
    end
  end

  // Address and pattern are shifted in MSB first while in their fields.
  always_ff @(posedge clk) begin
    if (rst) begin
      payload <= '0;
    end else if (receiving && in_fields) begin
      payload <= {payload[ADDR_W+PAT_W-2:0], line_bit};
    end
  end

  // BUF_DEPTH-entry buffer (two by default) between reception and the buffer memory engine.

  cvr_addr_type     fifo_addr [BUF_DEPTH];
  cvr_pat_type      fifo_pat  [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;

  wire logic fifo_full  = (count == CNT_FULL);
  wire logic fifo_empty = (count == '0);
  wire logic fifo_push  = pkt_good & ~fifo_full;
  wire logic fifo_drop  = pkt_good & fifo_full;
  logic      fifo_pop;

  // Ready also waits for buffer room, so a stalled memory holds the sender.
  assign link.vector_accept_ready = hunting & ~fifo_full;

  always_ff @(posedge clk) begin
    if (fifo_push) begin
      fifo_addr[wr_ptr] <= payload[ADDR_W+PAT_W-1:PAT_W];
      fifo_pat[wr_ptr]  <= payload[PAT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (fifo_push) begin
        wr_ptr <= wr_ptr + PTR_ONE;
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + PTR_ONE;
      end
      if (fifo_push && !fifo_pop) begin
        count <= count + CNT_ONE;
      end else if (fifo_pop && !fifo_push) begin
        count <= count - CNT_ONE;
      end
    end
  end

  // Read-modify-write engine; it runs beside reception without stalling it.

  cvr_rmw_state_type rmw_state;
  cvr_pat_type       pattern;

  wire logic        rmw_idle   = (rmw_state == CVR_IDLE);
  wire logic        read_done  = (rmw_state == CVR_READ) & mem_ack;
  wire logic        write_done = (rmw_state == CVR_WRITE) & mem_ack;
  wire cvr_pat_type fixed_byte = mem_rdata ^ pattern;
  wire logic        read_bad   = read_done & parity_check_enable &
                                 ~(^{mem_rdata, mem_rparity});

  assign fifo_pop = rmw_idle & ~fifo_empty;
  assign mem_req  = ~rmw_idle;
  assign mem_we   = (rmw_state == CVR_WRITE);

  always_ff @(posedge clk) begin
    if (rst) begin
      rmw_state <= CVR_IDLE;
    end else begin
      unique case (rmw_state)
        CVR_IDLE: begin
          if (fifo_pop) begin
            rmw_state <= CVR_READ;
          end
        end
        CVR_READ: begin
          if (mem_ack) begin
            rmw_state <= CVR_WRITE;
          end
        end
        CVR_WRITE: begin
          if (mem_ack) begin
            rmw_state <= CVR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr    <= '0;
      pattern     <= '0;
      mem_wdata   <= '0;
      mem_wparity <= 1'b0;
    end else if (fifo_pop) begin
      mem_addr    <= fifo_addr[rd_ptr];
      pattern     <= fifo_pat[rd_ptr];
    end else if (read_done) begin
      mem_wdata   <= fixed_byte;
      mem_wparity <= ~(^fixed_byte);
    end
  end

  // Status pulses; a failed packet never reaches the buffer.
  always_ff @(posedge clk) begin
    if (rst) begin
      link.vector_fault_flag <= 1'b0;
      correction_done        <= 1'b0;
      packet_dropped         <= 1'b0;
    end else begin
      link.vector_fault_flag <= pkt_bad | fifo_drop | read_bad;
      correction_done        <= write_done;
      packet_dropped         <= pkt_bad | fifo_drop;
    end
  end

endmodule

// [rtl/cvr_pkg.sv]
// Shared constants, types and the CRC step for the correction vector link.
package cvr_pkg;

  localparam int          ADDR_W        = 22;
  localparam int          PAT_W         = 8;
  localparam int          CRC_W         = 8;
  localparam int          SYNC_W        = 4;
  localparam int          PKT_BITS      = 42;
  localparam int          BODY_BITS     = SYNC_W + ADDR_W + PAT_W;

  localparam logic [3:0]  SYNC_PATTERN  = 4'hd;
  localparam logic [7:0]  CRC_POLY      = 8'h85;
  localparam logic [7:0]  CRC_INIT      = 8'h00;

  localparam logic [5:0]  POS_ADDR      = 6'h04;
  localparam logic [5:0]  POS_CHECK     = 6'h22;
  localparam logic [5:0]  POS_LAST      = 6'h29;
  localparam logic [5:0]  POS_ZERO      = 6'h00;
  localparam logic [5:0]  POS_STEP      = 6'h01;

  typedef logic [ADDR_W-1:0] cvr_addr_type;
  typedef logic [PAT_W-1:0]  cvr_pat_type;
  typedef logic [CRC_W-1:0]  cvr_crc_type;

  typedef enum logic [1:0] {
    CVR_HUNT = 2'b01,
    CVR_RECV = 2'b10
  } cvr_rx_state_type;

  typedef enum logic [2:0] {
    CVR_IDLE  = 3'b001,
    CVR_READ  = 3'b010,
    CVR_WRITE = 3'b100
  } cvr_rmw_state_type;

  typedef enum logic [1:0] {
    CVR_TX_IDLE = 2'b01,
    CVR_TX_SEND = 2'b10
  } cvr_tx_state_type;

  // One serial step of the x^8+x^7+x^2+1 division, most significant first.
  function automatic cvr_crc_type cvr_crc_step(input cvr_crc_type crc,
                                               input logic        din);
    logic feedback;
    feedback = crc[CRC_W-1] ^ din;
    cvr_crc_step = {crc[CRC_W-2:0], 1'b0} ^ (feedback ? CRC_POLY : CRC_INIT);
  endfunction

  // Remainder after the sync nibble alone, starting from a cleared register.
  function automatic cvr_crc_type cvr_crc_after_sync();
    cvr_crc_type crc;
    crc = CRC_INIT;
    for (int i = SYNC_W - 1; i >= 0; i--) begin
      crc = cvr_crc_step(crc, SYNC_PATTERN[i]);
    end
    cvr_crc_after_sync = crc;
  endfunction

endpackage

// [rtl/cvr_link_if.sv]
// Serial correction vector link between the sender and the receiver.
`timescale 1ns/1ns
interface cvr_link_if;
  logic vector_data;
  logic vector_accept_ready;
  logic vector_fault_flag;

  modport device (
    input  vector_data,
    output vector_accept_ready,
    output vector_fault_flag
  );

  modport partner (
    output vector_data,
    input  vector_accept_ready,
    input  vector_fault_flag
  );
endinterface

// [rtl/cvr_sender.sv]
// Partner end: frames address and pattern into 42-bit vector packets.
`timescale 1ns/1ns
module cvr_sender
  import cvr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  cvr_link_if.partner       link,
  input  wire logic         send_valid,
  output wire logic         send_ready,
  input  wire cvr_addr_type send_addr,
  input  wire cvr_pat_type  send_pattern,
  output logic              send_busy,
  output logic              fault_seen
);

  cvr_tx_state_type         state;
  logic [PKT_BITS-1:0]      shifter;
  logic [5:0]               bit_idx;

  wire logic [BODY_BITS-1:0] body = {SYNC_PATTERN, send_addr, send_pattern};
  wire logic                 idle = (state == CVR_TX_IDLE);
  wire logic                 take = send_valid & send_ready;
  wire logic                 last = (bit_idx == POS_LAST);

  // A new packet starts only while the receiver offers ready.
  assign send_ready = idle & link.vector_accept_ready;

  // CRC over sync, address and pattern from a cleared register.
  function automatic cvr_crc_type body_crc(input logic [BODY_BITS-1:0] b);
    cvr_crc_type crc;
    crc = CRC_INIT;
    for (int i = BODY_BITS - 1; i >= 0; i--) begin
      crc = cvr_crc_step(crc, b[i]);
    end
    body_crc = crc;
  endfunction

  wire cvr_crc_type check_bits = body_crc(body);

  // The line shows the top of the shifter, one bit per clock, zero when idle.
  assign link.vector_data = shifter[PKT_BITS-1];

  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= CVR_TX_IDLE;
      shifter <= '0;
      bit_idx <= POS_ZERO;
    end else if (take) begin
      state   <= CVR_TX_SEND;
      shifter <= {body, check_bits};
      bit_idx <= POS_ZERO;
    end else if (state == CVR_TX_SEND) begin
      shifter <= {shifter[PKT_BITS-2:0], 1'b0};
      bit_idx <= bit_idx + POS_STEP;
      if (last) begin
        state <= CVR_TX_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      send_busy  <= 1'b0;
      fault_seen <= 1'b0;
    end else begin
      send_busy  <= take | ((state == CVR_TX_SEND) & ~last);
      fault_seen <= link.vector_fault_flag;
    end
  end

endmodule

// [tb/cvr_link_props.sv]
// Checker for the timing of the correction vector link.
`timescale 1ns/1ns
module cvr_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic vector_data,
  input wire logic vector_accept_ready,
  input wire logic vector_fault_flag
);
  logic [3:0] sh;
  logic       busy;
  logic [5:0] cnt;
  wire        hit = !busy && ({sh[2:0], vector_data} == 4'hd);

  // Shadow framer: busy covers the cycles after sync up to the last bit.
  always_ff @(posedge clk) begin
    if (rst || (busy && cnt == 6'h29)) begin
      sh   <= 4'h0;
      busy <= 1'b0;
    end else if (!busy) begin
      sh   <= {sh[2:0], vector_data};
      busy <= hit;
    end
  end

  always_ff @(posedge clk) begin
    cnt <= hit ? 6'h04 : cnt + 6'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_ready_drops: assert property (
    hit |=> !vector_accept_ready) else $error("ready kept after sync");
  a_low_in_frame: assert property (
    busy |-> !vector_accept_ready) else $error("ready high in packet");
  a_ready_returns: assert property (
    $fell(busy) |-> ##[0:200] vector_accept_ready)
    else $error("ready not restored");
  a_frame_length: assert property (
    $fell(vector_accept_ready) |-> ##37 !vector_accept_ready)
    else $error("ready rose before packet end");
  a_sync_pattern: assert property (
    $fell(vector_accept_ready) |-> $past(vector_data, 1) &&
    !$past(vector_data, 2) && $past(vector_data, 3) &&
    $past(vector_data, 4)) else $error("ready fell without sync");
  a_fault_pulse: assert property (
    vector_fault_flag |=> !vector_fault_flag) else $error("fault too long");
  a_sender_waits: assert property (
    !busy && sh == 4'h0 && vector_data |-> $past(vector_accept_ready))
    else $error("packet started while not ready");
  a_reset_state: assert property (
    $fell(rst) |-> vector_accept_ready && !vector_fault_flag)
    else $error("bad link state after reset");

  c_packet: cover property ($fell(busy));
  c_fault: cover property (vector_fault_flag);
  c_full: cover property ($fell(busy) ##1 !vector_accept_ready);
endmodule

// [tb/test_correction_vector_receiver.sv]
// Testbench: sender and receiver joined over the vector link.
`timescale 1ns/1ns
module test_correction_vector_receiver;
  import cvr_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         send_valid = 1'b0;
  logic         parity_en = 1'b0;
  logic         ack = 1'b0;
  logic         bad_par = 1'b0;
  logic         rpar = 1'b0;
  cvr_addr_type send_addr = 22'h000000;
  cvr_pat_type  send_pattern = 8'h00;
  cvr_pat_type  rdata = 8'h00;
  cvr_pat_type  mem [16];
  wire logic    send_ready, send_busy, fault_seen, mem_req, mem_we;
  wire logic    mem_wparity, correction_done, packet_dropped, mem_req2;
  wire logic    drop2;
  wire cvr_addr_type mem_addr;
  wire cvr_pat_type  mem_wdata;
  int num_errors = 0, check_count = 0, nflt = 0, nflt2 = 0, nreq2 = 0;
  int ndone = 0, mem_wait = 0, wcnt = 0;
  int nbusy = 0, nseen = 0, ndrop = 0, ndrop2 = 0;

  cvr_link_if cvr_link_if_i ();
  cvr_link_if cvr_link_if_b_i ();
  cvr_sender cvr_sender_i (.clk(clk), .rst(rst), .link(cvr_link_if_i),
    .send_valid(send_valid), .send_ready(send_ready),
    .send_addr(send_addr), .send_pattern(send_pattern),
    .send_busy(send_busy), .fault_seen(fault_seen));
  cvr_receiver cvr_receiver_i (.clk(clk), .rst(rst), .link(cvr_link_if_i),
    .parity_check_enable(parity_en), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wparity(mem_wparity),
    .mem_rdata(rdata), .mem_rparity(rpar), .mem_ack(ack),
    .correction_done(correction_done), .packet_dropped(packet_dropped));
  // Second receiver is fed by a raw driver that can corrupt packets.
  cvr_receiver cvr_receiver_b_i (.clk(clk), .rst(rst),
    .link(cvr_link_if_b_i), .parity_check_enable(1'b0),
    .mem_req(mem_req2), .mem_we(), .mem_addr(), .mem_wdata(),
    .mem_wparity(), .mem_rdata(8'h00), .mem_rparity(1'b0), .mem_ack(1'b0),
    .correction_done(), .packet_dropped(drop2));
  cvr_link_props cvr_link_props_i (.clk(clk), .rst(rst),
    .vector_data(cvr_link_if_i.vector_data),
    .vector_accept_ready(cvr_link_if_i.vector_accept_ready),
    .vector_fault_flag(cvr_link_if_i.vector_fault_flag));

  always #5 clk = ~clk;

  always @(negedge clk) begin
    nflt += (cvr_link_if_i.vector_fault_flag === 1'b1);
    nflt2 += (cvr_link_if_b_i.vector_fault_flag === 1'b1);
    nreq2 += (mem_req2 === 1'b1);
    ndone += (correction_done === 1'b1);
    nbusy += (send_busy === 1'b1);
    nseen += (fault_seen === 1'b1);
    ndrop += (packet_dropped === 1'b1);
    ndrop2 += (drop2 === 1'b1);
  end

  // Byte memory with odd parity; each phase is acked after mem_wait cycles.
  always @(negedge clk) begin
    if (mem_req !== 1'b1 || ack) begin
      ack = 1'b0;
      wcnt = 0;
    end else if (wcnt < mem_wait) wcnt++;
    else begin
      ack = 1'b1;
      rdata = mem[mem_addr[3:0]];
      rpar = ~^rdata ^ bad_par;
      if (mem_we) begin
        check("write parity", mem_wparity, ~^mem_wdata);
        mem[mem_addr[3:0]] = mem_wdata;
      end
    end
  end

  task automatic check(input string nm, input logic [41:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [41:0] frame(cvr_addr_type a, cvr_pat_type p);
    logic [33:0] b;
    logic [7:0]  c;
    b = {4'hd, a, p};
    c = 8'h00;
    for (int i = 33; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ (c[7] ^ b[i] ? 8'h85 : 8'h00);
    return {b, c};
  endfunction

  task automatic send(input cvr_addr_type a, input cvr_pat_type p,
                      output logic [41:0] bits, output logic [41:0] rdy);
    int n;
    n = 0;
    send_valid = 1'b1;
    send_addr = a;
    send_pattern = p;
    while (send_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("send ready", send_ready, 1'b1);
    @(negedge clk);
    send_valid = 1'b0;
    for (int k = 41; k >= 0; k--) begin
      bits[k] = cvr_link_if_i.vector_data;
      rdy[k] = cvr_link_if_i.vector_accept_ready;
      @(negedge clk);
    end
  endtask

  task automatic wait_done(input int n);
    int t;
    t = 0;
    while (ndone < n && t < 2000) begin
      @(negedge clk);
      t++;
    end
    check("done count", ndone, n);
  endtask

  task automatic raw(input logic [41:0] pk);
    for (int k = 41; k >= 0; k--) begin
      cvr_link_if_b_i.vector_data = pk[k];
      @(negedge clk);
    end
    cvr_link_if_b_i.vector_data = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic t_good();
    logic [41:0] b, r;
    cvr_pat_type e;
    int f, d, nb;
    f = nflt;
    d = ndone + 1;
    nb = nbusy;
    e = mem[5] ^ 8'h3c;
    send(22'h2aaaa5, 8'h3c, b, r);
    check("busy span", nbusy - nb, 42);
    check("wire frame", b, frame(22'h2aaaa5, 8'h3c));
    check("ready shape", r, 42'h3c000000000);
    check("ready back", cvr_link_if_i.vector_accept_ready, 1'b1);
    wait_done(d);
    check("corrected byte", mem[5], e);
    check("no fault", nflt, f);
    $display("test good packet finished");
  endtask

  task automatic t_full();
    logic [41:0] b, r;
    cvr_pat_type e [4];
    int d;
    mem_wait = 60;
    d = ndone + 3;
    for (int i = 1; i < 4; i++) e[i] = mem[i] ^ (8'h40 + 8'(i));
    for (int i = 1; i < 4; i++) begin
      send(22'h100000 + 22'(i), 8'h40 + 8'(i), b, r);
      check("stream frame", b,
            frame(22'h100000 + 22'(i), 8'h40 + 8'(i)));
    end
    check("buffer refuses", cvr_link_if_i.vector_accept_ready, 1'b0);
    wait_done(d);
    for (int i = 1; i < 4; i++)
      check("stalled write", mem[i], e[i]);
    check("ready after drain", cvr_link_if_i.vector_accept_ready, 1'b1);
    check("no drop", ndrop, 0);
    mem_wait = 0;
    $display("test stream and stall finished");
  endtask

  task automatic t_parity();
    logic [41:0] b, r;
    cvr_pat_type e;
    int f;
    parity_en = 1'b1;
    bad_par = 1'b1;
    f = nflt;
    e = mem[7] ^ 8'h81;
    send(22'h000007, 8'h81, b, r);
    wait_done(ndone + 1);
    check("parity fault", nflt, f + 1);
    check("write kept", mem[7], e);
    parity_en = 1'b0;
    send(22'h000008, 8'h18, b, r);
    wait_done(ndone + 1);
    check("parity ignored", nflt, f + 1);
    check("fault relayed", nseen, nflt);
    bad_par = 1'b0;
    $display("test parity finished");
  endtask

  task automatic t_crc();
    int f, q, g;
    f = nflt2;
    q = nreq2;
    g = ndrop2;
    raw(frame(22'h3fffff, 8'hff) ^ 42'h00000100000);
    check("bad crc fault", nflt2, f + 1);
    check("bad crc no access", nreq2, q);
    check("bad crc dropped", ndrop2, g + 1);
    raw(frame(22'h3fffff, 8'hff));
    check("good crc no fault", nflt2, f + 1);
    check("good crc access", nreq2 > q, 1'b1);
    // The engine never gets an ack, so two vectors fill the buffer.
    repeat (3) raw(frame(22'h000001, 8'h01));
    check("full refuses", cvr_link_if_b_i.vector_accept_ready, 1'b0);
    check("full drop fault", nflt2, f + 2);
    check("full drop count", ndrop2, g + 2);
    $display("test crc finished");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    cvr_link_if_b_i.vector_data = 1'b0;
    for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_good();
    t_full();
    t_parity();
    t_crc();
    tally_and_finish();
  end

  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
